//--- pkg/sram_ctrl_pkg.sv
`default_nettype none
package sram_ctrl_pkg;

	// ---------------------------------------------------------------
	// Geometry
	// ---------------------------------------------------------------
	localparam int ADDR_W  = 18;
	localparam int BURST_W = 2;
	localparam int DATA_W  = 16;
	localparam int PAR_W   = 2;
	localparam int LANES   = 2;
	localparam int LANE_W  = 9;
	localparam int BYTE_W  = 8;
	localparam int WORD_W  = 18;
	localparam int DEPTH   = 262144;

	// ---------------------------------------------------------------
	// Values after reset
	// ---------------------------------------------------------------
	localparam logic [ADDR_W-1:0]  RST_BASE  = 18'h0_0000;
	localparam logic [BURST_W-1:0] RST_STEP  = 2'h0;
	localparam logic [WORD_W-1:0]  RST_WORD  = 18'h0_0000;
	localparam logic               RST_VALID = 1'b0;
	localparam logic               RST_SYNC  = 1'b0;

	// ---------------------------------------------------------------
	// Access state
	// ---------------------------------------------------------------
	typedef enum logic {
		ST_IDLE,
		ST_BURST
	} burst_state_t;

endpackage
`default_nettype wire

//--- rtl/sram_store.sv
`timescale 1ns/100ps
`default_nettype none
module sram_store #(
	parameter int DEPTH  = sram_ctrl_pkg::DEPTH,
	parameter int ADDR_W = sram_ctrl_pkg::ADDR_W,
	parameter int LANES  = sram_ctrl_pkg::LANES,
	parameter int LANE_W = sram_ctrl_pkg::LANE_W
) (
	input  wire logic                      clock,
	input  wire logic [ADDR_W-1:0]         addr,
	input  wire logic [LANES-1:0]          lane_wr,
	input  wire logic [LANES*LANE_W-1:0]   wr_word,
	output logic      [LANES*LANE_W-1:0]   rd_word
);

	typedef struct packed {
		logic [DEPTH-1:0][LANES*LANE_W-1:0] mem;
	} store_t;

	store_t                    q;
	store_t                    d;
	logic [LANES*LANE_W-1:0]   merged;

	assign rd_word = q.mem[addr];

	// ---------------------------------------------------------------
	// Per-lane merge of write data with stored data
	// ---------------------------------------------------------------
	for (genvar i = 0; i < LANES; i++) begin : g_lane
		assign merged[i*LANE_W +: LANE_W] = lane_wr[i] ?
			wr_word[i*LANE_W +: LANE_W] : rd_word[i*LANE_W +: LANE_W];
	end

	always_comb begin
		d = q;
		if (|lane_wr) begin
			d.mem[addr] = merged;
		end
	end

	always_ff @(posedge clock) begin
		q <= d;
	end

endmodule
`default_nettype wire

//--- rtl/sync_burst_sram_control.sv
`timescale 1ns/100ps
`default_nettype none
module sync_burst_sram_control #(
	parameter int DEPTH  = sram_ctrl_pkg::DEPTH,
	parameter int ADDR_W = sram_ctrl_pkg::ADDR_W
) (
	input  wire logic                            clock,
	input  wire logic                            srst,
	input  wire logic [ADDR_W-1:0]               addr_in,
	input  wire logic                            controller_addr_strobe_n,
	input  wire logic                            processor_addr_strobe_n,
	input  wire logic                            burst_advance_n,
	input  wire logic                            burst_order,
	input  wire logic                            chip_sel1_n,
	input  wire logic                            chip_sel2,
	input  wire logic                            chip_sel3_n,
	input  wire logic                            lane_write_enable_n,
	input  wire logic [sram_ctrl_pkg::LANES-1:0] lane_write_select_n,
	input  wire logic                            all_lane_write_n,
	input  wire logic                            output_enable_n,
	input  wire logic                            sleep_req,
	input  wire logic [sram_ctrl_pkg::DATA_W-1:0] data_io_in,
	output logic      [sram_ctrl_pkg::DATA_W-1:0] data_io_out,
	output logic                                 data_io_oe,
	input  wire logic [sram_ctrl_pkg::PAR_W-1:0]  parity_io_in,
	output logic      [sram_ctrl_pkg::PAR_W-1:0]  parity_io_out,
	output logic                                 parity_io_oe
);

	localparam int BW = sram_ctrl_pkg::BURST_W;
	localparam int WW = sram_ctrl_pkg::WORD_W;
	localparam int LW = sram_ctrl_pkg::LANE_W;
	localparam int BY = sram_ctrl_pkg::BYTE_W;
	localparam int NL = sram_ctrl_pkg::LANES;

	typedef struct packed {
		logic                        order_meta;
		logic                        order_sync;
		logic                        sleep_meta;
		logic                        sleep_sync;
		sram_ctrl_pkg::burst_state_t state;
		logic [ADDR_W-1:0]           base;
		logic [BW-1:0]               step;
		logic                        rd_valid;
		logic [WW-1:0]               rd_word;
	} ctrl_t;

	ctrl_t             q;
	ctrl_t             d;
	logic              selected;
	logic              proc_take;
	logic              ctrl_take;
	logic              start;
	logic              deselect;
	logic              awake;
	logic              access;
	logic              wr_allow;
	logic [BW-1:0]     cur_low;
	logic [BW-1:0]     next_low;
	logic [BW-1:0]     next_step;
	logic [ADDR_W-1:0] acc_addr;
	logic [NL-1:0]     lane_req;
	logic [NL-1:0]     lane_wr;
	logic [WW-1:0]     wr_word;
	logic [WW-1:0]     mem_rd;

	// ---------------------------------------------------------------
	// Burst order
	// ---------------------------------------------------------------
	function automatic logic [BW-1:0] burst_low(
		input logic [BW-1:0] first,
		input logic [BW-1:0] count,
		input logic          interleave
	);
		logic [BW-1:0] r;
		if (interleave) begin
			r = first ^ count;
		end else begin
			r = BW'(first + count);
		end
		return r;
	endfunction

	// ---------------------------------------------------------------
	// Strobe qualification
	// ---------------------------------------------------------------
	assign selected  = ~chip_sel1_n & chip_sel2 & ~chip_sel3_n;
	assign proc_take = ~processor_addr_strobe_n & ~chip_sel1_n;
	assign ctrl_take = ~controller_addr_strobe_n & ~proc_take;
	assign start     = (proc_take | ctrl_take) & selected;
	assign deselect  = (proc_take | ctrl_take) & ~selected;
	assign awake     = ~q.sleep_sync;
	assign next_step = BW'(q.step + 2'h1);
	assign cur_low   = burst_low(q.base[BW-1:0], q.step, q.order_sync);
	assign next_low  = burst_low(q.base[BW-1:0], next_step, q.order_sync);

	// ---------------------------------------------------------------
	// Lane write gating
	// ---------------------------------------------------------------
	always_comb begin
		if (!all_lane_write_n) begin
			lane_req = '1;
		end else if (!lane_write_enable_n) begin
			lane_req = ~lane_write_select_n;
		end else begin
			lane_req = '0;
		end
	end

	assign lane_wr = (access & wr_allow) ? lane_req : '0;
	assign wr_word = {parity_io_in[1], data_io_in[2*BY-1:BY],
		parity_io_in[0], data_io_in[BY-1:0]};

	// ---------------------------------------------------------------
	// Access decode
	// ---------------------------------------------------------------
	always_comb begin
		access   = 1'b0;
		wr_allow = 1'b0;
		acc_addr = {q.base[ADDR_W-1:BW], cur_low};
		if (awake && start) begin
			acc_addr = addr_in;
			access   = 1'b1;
			wr_allow = ctrl_take;
		end else if (awake && !deselect
				&& q.state == sram_ctrl_pkg::ST_BURST) begin
			access   = 1'b1;
			wr_allow = 1'b1;
			if (!burst_advance_n) begin
				acc_addr = {q.base[ADDR_W-1:BW], next_low};
			end
		end
	end

	// ---------------------------------------------------------------
	// Control state
	// ---------------------------------------------------------------
	always_comb begin
		d            = q;
		d.order_meta = burst_order;
		d.order_sync = q.order_meta;
		d.sleep_meta = sleep_req;
		d.sleep_sync = q.sleep_meta;
		if (!awake) begin
			d.rd_valid = 1'b0;
		end else if (start) begin
			d.state = sram_ctrl_pkg::ST_BURST;
			d.base  = addr_in;
			d.step  = sram_ctrl_pkg::RST_STEP;
		end else if (deselect) begin
			d.state    = sram_ctrl_pkg::ST_IDLE;
			d.rd_valid = 1'b0;
		end else begin
			case (q.state)
				sram_ctrl_pkg::ST_BURST: begin
					if (!burst_advance_n) begin
						d.step = next_step;
					end
				end
				sram_ctrl_pkg::ST_IDLE: begin
					d.state = sram_ctrl_pkg::ST_IDLE;
				end
				default: begin
					d.state = sram_ctrl_pkg::ST_IDLE;
				end
			endcase
		end
		if (access) begin
			if (|lane_wr) begin
				d.rd_valid = 1'b0;
			end else begin
				d.rd_valid = 1'b1;
				d.rd_word  = mem_rd;
			end
		end
		if (srst) begin
			d.order_meta = sram_ctrl_pkg::RST_SYNC;
			d.order_sync = sram_ctrl_pkg::RST_SYNC;
			d.sleep_meta = sram_ctrl_pkg::RST_SYNC;
			d.sleep_sync = sram_ctrl_pkg::RST_SYNC;
			d.state      = sram_ctrl_pkg::ST_IDLE;
			d.base       = ADDR_W'(sram_ctrl_pkg::RST_BASE);
			d.step       = sram_ctrl_pkg::RST_STEP;
			d.rd_valid   = sram_ctrl_pkg::RST_VALID;
			d.rd_word    = sram_ctrl_pkg::RST_WORD;
		end
	end

	always_ff @(posedge clock) begin
		q <= d;
	end

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	sram_store #(
		.DEPTH  (DEPTH),
		.ADDR_W (ADDR_W),
		.LANES  (NL),
		.LANE_W (LW)
	) u_store (
		.clock   (clock),
		.addr    (acc_addr),
		.lane_wr (lane_wr),
		.wr_word (wr_word),
		.rd_word (mem_rd)
	);

	// ---------------------------------------------------------------
	// Pins
	// ---------------------------------------------------------------
	assign data_io_out   = {q.rd_word[LW+BY-1:LW], q.rd_word[BY-1:0]};
	assign parity_io_out = {q.rd_word[2*LW-1], q.rd_word[LW-1]};
	assign data_io_oe    = q.rd_valid & ~output_enable_n;
	assign parity_io_oe  = q.rd_valid & ~output_enable_n;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	AST_CTRL_CAPTURE: assert property (
		awake && ctrl_take && selected |=> q.base == $past(addr_in))
		else $error("controller strobe did not capture the address");

	AST_PROC_FIRST: assert property (
		awake && proc_take && selected |-> lane_wr == '0)
		else $error("processor start did not override controller");

	AST_CS1_GATE: assert property (
		chip_sel1_n && controller_addr_strobe_n |=> $stable(q.base))
		else $error("processor strobe acted with select 1 high");

	AST_UPPER_HOLD: assert property (
		!start |=> q.base[ADDR_W-1:BW] == $past(q.base[ADDR_W-1:BW]))
		else $error("upper address changed without a start");

	AST_STEP: assert property (
		awake && !start && !deselect && q.state == sram_ctrl_pkg::ST_BURST
		&& !burst_advance_n |=> q.step == BW'($past(q.step) + 2'h1))
		else $error("burst counter did not step");

	AST_FIRST_LOW: assert property (
		awake && start |-> ##1 cur_low == $past(addr_in[BW-1:0]))
		else $error("burst start value not loaded");

	AST_ALL_LANES: assert property (
		access && wr_allow && !all_lane_write_n |-> lane_wr == 2'b11)
		else $error("all-lane write missed a lane");

	AST_NO_BYTE_WR: assert property (
		all_lane_write_n && lane_write_enable_n |-> lane_wr == '0)
		else $error("byte write without lane write enable");

	AST_WRITE_HIZ: assert property (
		|lane_wr |=> !data_io_oe && !parity_io_oe)
		else $error("outputs driven after a write");

	AST_READ_DRIVE: assert property (
		access && lane_wr == '0
		|=> q.rd_valid && (data_io_oe == !output_enable_n))
		else $error("read data not driven one edge later");

	AST_OE_OFF: assert property (
		output_enable_n |-> !data_io_oe && !parity_io_oe)
		else $error("pins driven with output enable high");

endmodule
`default_nettype wire

//--- tb/bus_master_model.sv
`timescale 1ns/100ps
`default_nettype none
// ------
// Shared data wire, master side wins
// ------
module bus_master_model (
	input  wire logic        clock,
	input  wire logic [17:0] m_word,
	input  wire logic        m_drive,
	input  wire logic [17:0] s_word,
	input  wire logic        s_drive,
	output logic      [17:0] wire_word
);
	logic [17:0] last_q = 18'h0_0000;
	always_comb begin
		if (m_drive) begin
			wire_word = m_word;
		end else if (s_drive) begin
			wire_word = s_word;
		end else begin
			wire_word = ~last_q;
		end
	end
	always @(posedge clock) begin
		last_q <= wire_word;
	end
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic [3:0]  a;
		logic [17:0] w;
		logic        p;
	} row_t;
	row_t        rows [8] = '{
		'{4'h0, 18'h2_0A51, 1'h0}, '{4'h1, 18'h1_3C07, 1'h1},
		'{4'h2, 18'h0_55AA, 1'h0}, '{4'h3, 18'h3_AA55, 1'h1},
		'{4'h4, 18'h0_0F0F, 1'h0}, '{4'h5, 18'h2_F0F0, 1'h1},
		'{4'h6, 18'h1_8001, 1'h0}, '{4'h7, 18'h3_7FFE, 1'h1}};
	logic        clock = 1'h0, srst = 1'h1;
	logic [3:0]  addr_in = 4'h0;
	logic        controller_addr_strobe_n = 1'h1;
	logic        processor_addr_strobe_n = 1'h1;
	logic        burst_advance_n = 1'h1, burst_order = 1'h0;
	logic        chip_sel1_n = 1'h0, chip_sel2 = 1'h1, chip_sel3_n = 1'h0;
	logic        lane_write_enable_n = 1'h1, all_lane_write_n = 1'h1;
	logic [1:0]  lane_write_select_n = 2'h3;
	logic        output_enable_n = 1'h0, m_drive = 1'h0;
	logic [17:0] m_word = 18'h0_0000;
	logic [17:0] wire_word, word;
	logic [15:0] data_io_out;
	logic [1:0]  parity_io_out, st, idx;
	logic        data_io_oe, parity_io_oe;
	int          err_total = 0, num_checks = 0;
	assign word = {parity_io_out[1], data_io_out[15:8],
		parity_io_out[0], data_io_out[7:0]};
	always #5 clock = ~clock;
	bus_master_model partner (.clock(clock), .m_word(m_word),
		.m_drive(m_drive), .s_word(word), .s_drive(data_io_oe),
		.wire_word(wire_word));
	sync_burst_sram_control #(.DEPTH(16), .ADDR_W(4)) dut (
		.clock(clock), .srst(srst), .addr_in(addr_in),
		.controller_addr_strobe_n(controller_addr_strobe_n),
		.processor_addr_strobe_n(processor_addr_strobe_n),
		.burst_advance_n(burst_advance_n), .burst_order(burst_order),
		.chip_sel1_n(chip_sel1_n), .chip_sel2(chip_sel2),
		.chip_sel3_n(chip_sel3_n),
		.lane_write_enable_n(lane_write_enable_n),
		.lane_write_select_n(lane_write_select_n),
		.all_lane_write_n(all_lane_write_n),
		.output_enable_n(output_enable_n), .sleep_req(1'h0),
		.data_io_in({wire_word[16:9], wire_word[7:0]}),
		.data_io_out(data_io_out), .data_io_oe(data_io_oe),
		.parity_io_in({wire_word[17], wire_word[8]}),
		.parity_io_out(parity_io_out), .parity_io_oe(parity_io_oe));
	// ------
	// Compares and bus cycles
	// ------
	task automatic cmp_word(input logic [17:0] got, input logic [17:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t word %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t enable %b expected %b", $time, got, exp);
		end
	endtask
	task automatic strobe(input logic c, input logic p, input logic g,
			input logic be, input logic [1:0] bs, input logic [3:0] a,
			input logic [17:0] d);
		@(posedge clock);
		controller_addr_strobe_n <= c;
		processor_addr_strobe_n <= p;
		all_lane_write_n <= g;
		lane_write_enable_n <= be;
		lane_write_select_n <= bs;
		addr_in <= a;
		m_word <= d;
		m_drive <= ~(g & be);
		@(posedge clock);
		controller_addr_strobe_n <= 1'h1;
		processor_addr_strobe_n <= 1'h1;
		all_lane_write_n <= 1'h1;
		lane_write_enable_n <= 1'h1;
		lane_write_select_n <= 2'h3;
		m_drive <= 1'h0;
	endtask
	task automatic settle;
		repeat (3) @(posedge clock);
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input logic p);
		strobe(p, ~p, 1'h1, 1'h1, 2'h3, a, 18'h0_0000);
		settle();
	endtask
	task automatic give_verdict;
		if (err_total == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ------
	// Sequence
	// ------
	initial begin
		repeat (6) @(posedge clock);
		srst <= 1'h0;
		#1;
		cmp_bit(data_io_oe, 1'h0);
		foreach (rows[i]) begin
			strobe(1'h0, 1'h1, 1'h0, 1'h1, 2'h3, rows[i].a, rows[i].w);
		end
		foreach (rows[i]) begin
			rd(rows[i].a, rows[i].p);
			cmp_word(word, rows[i].w);
			cmp_bit(data_io_oe, 1'h1);
		end
		for (int o = 0; o < 2; o++) begin
			@(posedge clock);
			burst_order <= o[0];
			repeat (3) @(posedge clock);
			rd(4'h5, 1'h0);
			cmp_word(word, rows[5].w);
			for (int s = 1; s < 5; s++) begin
				@(posedge clock);
				burst_advance_n <= 1'h0;
				@(posedge clock);
				burst_advance_n <= 1'h1;
				settle();
				st = s[1:0];
				idx = o[0] ? (2'h1 ^ st) : (2'h1 + st);
				cmp_word(word, rows[{2'h1, idx}].w);
			end
		end
		strobe(1'h0, 1'h1, 1'h1, 1'h0, 2'h2, 4'h2, 18'h3_FFFF);
		#1;
		cmp_bit(data_io_oe, 1'h0);
		cmp_bit(parity_io_oe, 1'h0);
		strobe(1'h0, 1'h1, 1'h1, 1'h1, 2'h0, 4'h3, 18'h0_0000);
		rd(4'h2, 1'h0);
		cmp_word(word, {rows[2].w[17:9], 9'h1FF});
		rd(4'h3, 1'h0);
		cmp_word(word, rows[3].w);
		strobe(1'h0, 1'h0, 1'h0, 1'h1, 2'h3, 4'h6, 18'h0_0000);
		settle();
		cmp_word(word, rows[6].w);
		@(posedge clock);
		chip_sel1_n <= 1'h1;
		strobe(1'h1, 1'h0, 1'h1, 1'h1, 2'h3, 4'h0, 18'h0_0000);
		chip_sel1_n <= 1'h0;
		settle();
		cmp_word(word, rows[6].w);
		for (int k = 0; k < 3; k++) begin
			@(posedge clock);
			chip_sel1_n <= (k == 0);
			chip_sel2 <= (k != 1);
			chip_sel3_n <= (k == 2);
			strobe(1'h0, 1'h1, 1'h0, 1'h1, 2'h3, 4'h7, 18'h0_0000);
			chip_sel1_n <= 1'h0;
			chip_sel2 <= 1'h1;
			chip_sel3_n <= 1'h0;
			rd(4'h7, 1'h0);
			cmp_word(word, rows[7].w);
		end
		@(posedge clock);
		output_enable_n <= 1'h1;
		#2;
		cmp_bit(data_io_oe, 1'h0);
		cmp_bit(parity_io_oe, 1'h0);
		@(posedge clock);
		output_enable_n <= 1'h0;
		#2;
		cmp_bit(data_io_oe, 1'h1);
		cmp_bit(parity_io_oe, 1'h1);
		@(posedge clock);
		srst <= 1'h1;
		@(posedge clock);
		srst <= 1'h0;
		#1;
		cmp_bit(data_io_oe, 1'h0);
		rd(4'h7, 1'h0);
		cmp_word(word, rows[7].w);
		give_verdict();
	end
endmodule
`default_nettype wire
